// File: design/bitbr_pkg.sv
// Shared types and constants for the bit-operation and relative-branch execution block.
// Assumes a core with 7-bit file addresses, 8-bit data and a 15-bit program counter.
package bitbr_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BIT_W  = 3;
    localparam int PC_W   = 15;
    localparam int LIT_W  = 9;
    localparam logic [PC_W-1:0] PC_ONE   = 15'h0001;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_LIT_BRANCH,
        OP_REG_BRANCH,
        OP_SKIP_CLEAR,
        OP_SKIP_SET
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [BIT_W-1:0]  bit_sel;
        logic [LIT_W-1:0]  lit;
    } instr_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;

    typedef enum logic [1:0] {
        ST_READY,
        ST_FLUSH
    } phase_t;
endpackage

// File: design/bit_op_and_branch_exec.sv
// Execution unit for bit clear/set, bit test with skip, and relative branches.
// Assumes decode presents one instruction per cycle with valid_i, that the current
// register value arrives on file_rdata_i for instr_i.addr in the same cycle, and
// that pc_i already holds the incremented program counter (address of next word).
//
// Contract
// - Bit clear zeroes bit b of file register f, others kept, no flags.
// - Bit set forces bit b of file register f high, others kept, no flags.
// - Literal branch loads PC with incremented PC plus sign-extended 9-bit k.
// - Literal branch takes two cycles and leaves status flags alone.
// - Register branch loads PC with next address plus unsigned working register.
// - Register branch takes two cycles and leaves status flags alone.
// - Skip-if-clear discards next instruction as no-op when tested bit is zero.
// - Skip-if-set discards next instruction as no-op when tested bit is one.
`timescale 1ns/1ps
`default_nettype none
module bit_op_and_branch_exec (
    input  wire logic                           clk_i,
    input  wire logic                           nrst_i,
    input  wire logic                           valid_i,
    input  wire bitbr_pkg::instr_t              instr_i,
    input  wire logic [bitbr_pkg::DATA_W-1:0]   file_rdata_i,
    input  wire logic [bitbr_pkg::DATA_W-1:0]   wreg_i,
    input  wire logic [bitbr_pkg::PC_W-1:0]     pc_i,
    output logic                                busy_o,
    output logic                                flush_o,
    output logic                                pc_load_o,
    output logic [bitbr_pkg::PC_W-1:0]          pc_target_o,
    output var bitbr_pkg::file_wr_t             file_wr_o,
    output logic                                status_we_o
);
    typedef struct packed {
        bitbr_pkg::phase_t          phase;
        logic                       busy;
        logic                       status_we;
        logic                       flush;
        logic                       pc_load;
        logic [bitbr_pkg::PC_W-1:0] pc_target;
        bitbr_pkg::file_wr_t        wr;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    logic [bitbr_pkg::DATA_W-1:0] mask;
    logic                         tested;
    logic                         take;

    always_comb begin
        mask   = bitbr_pkg::DATA_ONE << instr_i.bit_sel;
        tested = file_rdata_i[instr_i.bit_sel];
        take   = valid_i && (state_ff.phase == bitbr_pkg::ST_READY);
        nxt_state         = state_ff;
        nxt_state.flush   = 1'b0;
        nxt_state.pc_load = 1'b0;
        nxt_state.wr.we   = 1'b0;
        nxt_state.phase   = bitbr_pkg::ST_READY;
        // The second cycle of a two-cycle op accepts nothing, so the fetched word is dropped.
        if (take) begin
            unique case (instr_i.op)
                bitbr_pkg::OP_BIT_CLEAR: begin
                    nxt_state.wr.we   = 1'b1;
                    nxt_state.wr.addr = instr_i.addr;
                    nxt_state.wr.data = file_rdata_i & ~mask;
                end
                bitbr_pkg::OP_BIT_SET: begin
                    nxt_state.wr.we   = 1'b1;
                    nxt_state.wr.addr = instr_i.addr;
                    nxt_state.wr.data = file_rdata_i | mask;
                end
                bitbr_pkg::OP_LIT_BRANCH: begin
                    nxt_state.pc_load   = 1'b1;
                    nxt_state.pc_target = pc_i + {{(bitbr_pkg::PC_W-bitbr_pkg::LIT_W){instr_i.lit[bitbr_pkg::LIT_W-1]}},
                                                  instr_i.lit};
                    nxt_state.flush     = 1'b1;
                    nxt_state.phase     = bitbr_pkg::ST_FLUSH;
                end
                bitbr_pkg::OP_REG_BRANCH: begin
                    nxt_state.pc_load   = 1'b1;
                    nxt_state.pc_target = pc_i + {{(bitbr_pkg::PC_W-bitbr_pkg::DATA_W){1'b0}}, wreg_i};
                    nxt_state.flush     = 1'b1;
                    nxt_state.phase     = bitbr_pkg::ST_FLUSH;
                end
                bitbr_pkg::OP_SKIP_CLEAR: begin
                    if (!tested) begin
                        nxt_state.flush = 1'b1;
                        nxt_state.phase = bitbr_pkg::ST_FLUSH;
                    end
                end
                bitbr_pkg::OP_SKIP_SET: begin
                    if (tested) begin
                        nxt_state.flush = 1'b1;
                        nxt_state.phase = bitbr_pkg::ST_FLUSH;
                    end
                end
                // OP_NONE and any unused op code write nothing and end in their own cycle.
                default: begin
                    nxt_state.phase = bitbr_pkg::ST_READY;
                end
            endcase
        end
        // Busy is kept as its own flop so the port comes straight from a register.
        nxt_state.busy      = nxt_state.phase == bitbr_pkg::ST_FLUSH;
        nxt_state.status_we = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_ff <= '{phase: bitbr_pkg::ST_READY, busy: 1'b0, status_we: 1'b0, flush: 1'b0, pc_load: 1'b0,
                          pc_target: bitbr_pkg::PC_RESET, wr: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign busy_o      = state_ff.busy;
    assign flush_o     = state_ff.flush;
    assign pc_load_o   = state_ff.pc_load;
    assign pc_target_o = state_ff.pc_target;
    assign file_wr_o   = state_ff.wr;
    // None of these operations touch status flags, so the flag write strobe stays low.
    assign status_we_o = state_ff.status_we;
endmodule
`default_nettype wire

// File: verif/bitbr_checker.sv
// Port assertions for the bit-op and branch block.
// Bound below to every instance of that block.
`timescale 1ns/1ps
`default_nettype none
module bitbr_checker (
    input wire logic clk_i, nrst_i, valid_i, busy_o, flush_o, pc_load_o, status_we_o,
    input wire bitbr_pkg::instr_t instr_i,
    input wire logic [7:0] file_rdata_i, wreg_i,
    input wire logic [14:0] pc_i, pc_target_o,
    input wire bitbr_pkg::file_wr_t file_wr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic tk = valid_i && !busy_o;
    wire logic [7:0] m = 8'h01 << instr_i.bit_sel;
    wire logic hit = |(file_rdata_i & m);
    wire bitbr_pkg::op_t op = instr_i.op;
    a_clear_write: assert property (tk && op == bitbr_pkg::OP_BIT_CLEAR |=>
        file_wr_o.we && file_wr_o.addr == $past(instr_i.addr) && file_wr_o.data == $past(file_rdata_i & ~m))
        else $error("clear");
    a_set_write: assert property (tk && op == bitbr_pkg::OP_BIT_SET |=>
        file_wr_o.we && file_wr_o.addr == $past(instr_i.addr) && file_wr_o.data == $past(file_rdata_i | m))
        else $error("set");
    a_lit_target: assert property (tk && op == bitbr_pkg::OP_LIT_BRANCH |=>
        pc_load_o && pc_target_o == $past(pc_i + 15'($signed(instr_i.lit))) ##1 !busy_o) else $error("lit");
    a_reg_target: assert property (tk && op == bitbr_pkg::OP_REG_BRANCH |=>
        pc_load_o && pc_target_o == $past(pc_i + 15'(wreg_i)) ##1 !busy_o) else $error("reg");
    a_skip_clear: assert property (tk && op == bitbr_pkg::OP_SKIP_CLEAR && !hit |=>
        flush_o && busy_o ##1 !busy_o) else $error("skip clear");
    a_skip_set: assert property (tk && op == bitbr_pkg::OP_SKIP_SET && hit |=>
        flush_o && busy_o ##1 !busy_o) else $error("skip set");
    a_single_test: assert property (tk && hit == (op == bitbr_pkg::OP_SKIP_CLEAR) &&
        (op == bitbr_pkg::OP_SKIP_CLEAR || op == bitbr_pkg::OP_SKIP_SET) |=> !busy_o && !flush_o) else $error("test");
    a_flags_kept: assert property (!status_we_o) else $error("flags");
endmodule
bind bit_op_and_branch_exec bitbr_checker chk (.*);
`default_nettype wire

// File: verif/testbench.sv
// Directed bench for the bit-op and branch block.
// Assumes the package, block and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, nrst_i = 1'b0, valid_i = 1'b0, busy_o, flush_o, pc_load_o, status_we_o;
    logic [7:0] file_rdata_i = 8'h00, wreg_i = 8'h80;
    logic [14:0] pc_i = 15'h7F00, pc_target_o;
    bitbr_pkg::instr_t instr_i = '0;
    bitbr_pkg::file_wr_t file_wr_o;
    int num_errors = 0, compares = 0;
    bit_op_and_branch_exec dut (.*);
    always #25 clk_i = ~clk_i;
    task automatic chk(logic ok);
        compares++;
        num_errors += int'(ok !== 1'b1);
        if (ok !== 1'b1) $display("[FAIL] %0t check %0d", $time, compares);
    endtask
    task automatic go(bitbr_pkg::op_t o, logic [2:0] b, logic [8:0] k, logic [7:0] d);
        @(posedge clk_i);
        valid_i <= 1'b1;
        instr_i <= '{o, 7'h7F, b, k};
        file_rdata_i <= d;
        @(posedge clk_i);
        valid_i <= 1'b0;
        #1;
    endtask
    task automatic bit_ops();
        for (int i = 0; i < 16; i++) begin
            go(i[0] ? bitbr_pkg::OP_BIT_SET : bitbr_pkg::OP_BIT_CLEAR, i[3:1], 9'h000, {8{~i[0]}});
            chk(file_wr_o.we === 1'b1 && file_wr_o.addr === 7'h7F &&
                file_wr_o.data === (i[0] ? 8'h01 << i[3:1] : ~(8'h01 << i[3:1])));
        end
    endtask
    task automatic flow();
        go(bitbr_pkg::OP_LIT_BRANCH, 3'h0, 9'h100, 8'h00);
        chk(pc_load_o === 1'b1 && flush_o === 1'b1 && busy_o === 1'b1 && pc_target_o === 15'h7E00);
        go(bitbr_pkg::OP_REG_BRANCH, 3'h0, 9'h000, 8'h00);
        chk(busy_o === 1'b1 && pc_target_o === 15'h7F80);
        for (int i = 0; i < 4; i++) begin
            go(i[0] ? bitbr_pkg::OP_SKIP_SET : bitbr_pkg::OP_SKIP_CLEAR, 3'h0, 9'h000, {7'h00, i[1]});
            chk(flush_o === (i[0] == i[1]) && busy_o === flush_o && file_wr_o.we === 1'b0);
        end
        chk(status_we_o === 1'b0);
    endtask
    task automatic refused();
        @(posedge clk_i);
        valid_i <= 1'b1;
        instr_i <= '{bitbr_pkg::OP_REG_BRANCH, 7'h7F, 3'h0, 9'h000};
        @(posedge clk_i);
        instr_i <= '{bitbr_pkg::OP_BIT_SET, 7'h01, 3'h2, 9'h000};
        #1;
        chk(busy_o === 1'b1 && pc_load_o === 1'b1);
        @(posedge clk_i);
        valid_i <= 1'b0;
        #1;
        chk(busy_o === 1'b0 && file_wr_o.we === 1'b0 && pc_load_o === 1'b0 && flush_o === 1'b0);
    endtask
    task automatic summarize();
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        bit_ops();
        flow();
        refused();
        summarize();
    end
    initial begin
        repeat (200) @(posedge clk_i);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
